// file: dhbp_consts.svh
`ifndef DHBP_CONSTS_SVH
`define DHBP_CONSTS_SVH
`define DHBP_REG_W     16
`define DHBP_BYTE_W    8
`define DHBP_HI_MSB    15
`define DHBP_HI_LSB    8
`define DHBP_LO_MSB    7
`define DHBP_LO_LSB    0
`define DHBP_SEL_STAT  1'h1
`define DHBP_SEL_DATA  1'h0
`define DHBP_BYTE_HI   1'h1
`define DHBP_ST_OUTF   0
`define DHBP_ST_INF    1
`endif

// file: dhbp_pkg.sv
package dhbp_pkg;
	typedef struct packed {
		logic register_select_line;
		logic byte_select_line;
		logic port_chip_select_n;
		logic port_read_strobe_n;
		logic port_write_strobe_n;
	} dhbp_ctl_type;
	typedef enum logic [1:0] {DHBP_IDLE, DHBP_READ, DHBP_WRITE} dhbp_state_type;
endpackage

// file: dhbp_host_port.sv
`timescale 1ns/1ps
`include "dhbp_consts.svh"
// How it works
// - select high reaches the status register
// - select low read returns outbound data
// - select low write captures inbound data
// - byte select high moves bits 15..8
// - byte select low moves bits 7..0
// - data lines driven only during reads
module dhbp_host_port
	import dhbp_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire dhbp_ctl_type ctl_pin,
	input  wire logic [7:0]  port_data_lines_in,
	output logic      [7:0]  port_data_lines_out,
	output logic             port_data_lines_oe,
	output logic             read_enable_indication_r,
	output logic             write_enable_indication_r,
	input  wire logic [15:0] core_outbound_data,
	input  wire logic        core_outbound_load,
	input  wire logic        core_inbound_take,
	output logic      [15:0] host_inbound_data_r,
	output logic             inbound_valid_r
);
	dhbp_ctl_type ctl_s1_r, ctl_s2_r;
	dhbp_state_type state_r;
	logic [15:0] host_outbound_data_r;
	logic        outbound_full_r;
	logic [15:0] host_port_status;
	logic        rd_act, wr_act;

	// pins are asynchronous to ref_clk
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_s1_r <= 5'h1F;
			ctl_s2_r <= 5'h1F;
		end else begin
			ctl_s1_r <= ctl_pin;
			ctl_s2_r <= ctl_s1_r;
		end
	end

	// data pins take the same two-flop path as the strobes,
	// so data and strobe are seen together on one edge
	logic [7:0] din_s1_r, din_s2_r;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			din_s1_r <= 8'h00;
			din_s2_r <= 8'h00;
		end else begin
			din_s1_r <= port_data_lines_in;
			din_s2_r <= din_s1_r;
		end
	end

	// read wins if host asserts both strobes
	assign rd_act = !ctl_s2_r.port_chip_select_n && !ctl_s2_r.port_read_strobe_n;
	assign wr_act = !ctl_s2_r.port_chip_select_n && !ctl_s2_r.port_write_strobe_n
		&& ctl_s2_r.port_read_strobe_n;

	// status layout: bit 0 outbound full, bit 1 inbound valid, rest zero
	always_comb begin
		host_port_status = 16'h0000;
		host_port_status[`DHBP_ST_OUTF] = outbound_full_r;
		host_port_status[`DHBP_ST_INF] = inbound_valid_r;
	end

	// one lane selector for status and outbound reads alike
	function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic hi);
		pick_byte = (hi == `DHBP_BYTE_HI) ? w[`DHBP_HI_MSB:`DHBP_HI_LSB]
			: w[`DHBP_LO_MSB:`DHBP_LO_LSB];
	endfunction

	// one access per strobe: act on the entry edge only
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= DHBP_IDLE;
		end else begin
			case (state_r)
				DHBP_IDLE: begin
					if (rd_act)
						state_r <= DHBP_READ;
					else if (wr_act)
						state_r <= DHBP_WRITE;
				end
				DHBP_READ: if (!rd_act) state_r <= DHBP_IDLE;
				DHBP_WRITE: if (!wr_act) state_r <= DHBP_IDLE;
				default: state_r <= DHBP_IDLE;
			endcase
		end
	end

	// out follows the selects every clock; only oe gates the pins
	// bus drive: data only while a read is under way
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			port_data_lines_out <= 8'h00;
			port_data_lines_oe  <= 1'b0;
		end else begin
			port_data_lines_oe <= rd_act;
			if (ctl_s2_r.register_select_line == `DHBP_SEL_STAT)
				port_data_lines_out <= pick_byte(host_port_status,
					ctl_s2_r.byte_select_line);
			else
				port_data_lines_out <= pick_byte(host_outbound_data_r,
					ctl_s2_r.byte_select_line);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			host_inbound_data_r <= 16'h0000;
			inbound_valid_r     <= 1'b0;
		end else begin
			// low byte first: the high byte write marks the word complete
			if (state_r == DHBP_IDLE && wr_act
				&& ctl_s2_r.register_select_line == `DHBP_SEL_DATA) begin
				if (ctl_s2_r.byte_select_line == `DHBP_BYTE_HI) begin
					host_inbound_data_r[`DHBP_HI_MSB:`DHBP_HI_LSB] <= din_s2_r;
					inbound_valid_r <= 1'b1;
				end else begin
					host_inbound_data_r[`DHBP_LO_MSB:`DHBP_LO_LSB] <= din_s2_r;
				end
			end else if (core_inbound_take) begin
				inbound_valid_r <= 1'b0;
			end
		end
	end

	// high byte read completes the outbound word
	// a core load on the clearing edge wins: that word is new
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			host_outbound_data_r <= 16'h0000;
			outbound_full_r      <= 1'b0;
		end else if (core_outbound_load) begin
			host_outbound_data_r <= core_outbound_data;
			outbound_full_r      <= 1'b1;
		end else if (state_r == DHBP_IDLE && rd_act
			&& ctl_s2_r.register_select_line == `DHBP_SEL_DATA
			&& ctl_s2_r.byte_select_line == `DHBP_BYTE_HI) begin
			outbound_full_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			read_enable_indication_r  <= 1'b0;
			write_enable_indication_r <= 1'b1;
		end else begin
			// indications trail the flags by one clock; a polling host
			// may still see the old level right after its access
			read_enable_indication_r  <= outbound_full_r;
			write_enable_indication_r <= !inbound_valid_r;
		end
	end

	// host-visible bus checks
	a_drive_on_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rd_act |=> port_data_lines_oe) else $error("read not driven");
	a_release_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!rd_act |=> !port_data_lines_oe) else $error("bus not released");
	a_status_lo: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rd_act && ctl_s2_r.register_select_line && !ctl_s2_r.byte_select_line
		|=> port_data_lines_out == $past(host_port_status[7:0]))
		else $error("status low byte wrong");
	a_outbound_hi: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rd_act && !ctl_s2_r.register_select_line && ctl_s2_r.byte_select_line
		&& !core_outbound_load |=> port_data_lines_out == host_outbound_data_r[15:8])
		else $error("outbound high byte wrong");
	a_outbound_lo: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rd_act && !ctl_s2_r.register_select_line && !ctl_s2_r.byte_select_line
		&& !core_outbound_load |=> port_data_lines_out == host_outbound_data_r[7:0])
		else $error("outbound low byte wrong");
	a_inbound_hi: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state_r == DHBP_IDLE && wr_act && !ctl_s2_r.register_select_line
		&& ctl_s2_r.byte_select_line |=> host_inbound_data_r[15:8] == $past(din_s2_r)
		&& inbound_valid_r) else $error("inbound high byte lost");
	a_inbound_lo: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state_r == DHBP_IDLE && wr_act && !ctl_s2_r.register_select_line
		&& !ctl_s2_r.byte_select_line |=> host_inbound_data_r[7:0] == $past(din_s2_r))
		else $error("inbound low byte lost");
	a_status_no_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_act && ctl_s2_r.register_select_line && !core_inbound_take
		|=> $stable(host_inbound_data_r)) else $error("status write leaked");

	// lanes, deselect and the core-side flag handshakes
	a_status_hi: assert property (@(posedge ref_clk) disable iff (!rst_n)
		rd_act && ctl_s2_r.register_select_line && ctl_s2_r.byte_select_line
		|=> port_data_lines_out == $past(host_port_status[15:8]))
		else $error("status high byte wrong");
	a_deselect_no_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ctl_s2_r.port_chip_select_n |=> $stable(host_inbound_data_r))
		else $error("write without chip select");
	a_outbound_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state_r == DHBP_IDLE && rd_act && !ctl_s2_r.register_select_line
		&& ctl_s2_r.byte_select_line && !core_outbound_load |=> !outbound_full_r)
		else $error("outbound full not cleared");
	a_low_read_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state_r == DHBP_IDLE && rd_act && !ctl_s2_r.register_select_line
		&& !ctl_s2_r.byte_select_line && !core_outbound_load |=> $stable(outbound_full_r))
		else $error("low byte read cleared full");
	a_low_write_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state_r == DHBP_IDLE && wr_act && !ctl_s2_r.register_select_line
		&& !ctl_s2_r.byte_select_line && !core_inbound_take |=> $stable(inbound_valid_r))
		else $error("low byte write set valid");
	a_write_once: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state_r == DHBP_WRITE |=> $stable(host_inbound_data_r))
		else $error("second capture in one strobe");
	a_take_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
		core_inbound_take && !(state_r == DHBP_IDLE && wr_act
		&& !ctl_s2_r.register_select_line && ctl_s2_r.byte_select_line)
		|=> !inbound_valid_r)
		else $error("inbound valid not cleared");
	a_load_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
		core_outbound_load |=> outbound_full_r
		&& host_outbound_data_r == $past(core_outbound_data))
		else $error("outbound load lost");
	a_deselect_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ctl_s2_r.port_chip_select_n |=> !port_data_lines_oe)
		else $error("bus driven while deselected");
endmodule

// file: dhbp_host_model.sv
`timescale 1ns/1ps
module dhbp_host_model
	import dhbp_pkg::*;
(
	input  wire logic [7:0] bus,
	input  wire logic       ref_clk,
	output dhbp_ctl_type    ctl,
	output logic      [7:0] hd,
	output logic            hoe
);
	initial begin
		ctl = 5'h07;
		hd = 8'h00;
		hoe = 1'b0;
	end
	// pins held 5 clocks, idle 4: covers the 2-flop synchroniser
	task automatic access(input logic rs, input logic bs, input logic wr,
		input logic [7:0] d, output logic [7:0] q);
		@(negedge ref_clk);
		ctl = {rs, bs, 1'b0, wr, !wr};
		hd = d;
		hoe = wr;
		repeat (5) @(negedge ref_clk);
		q = bus;
		ctl = {rs, bs, 3'h7};
		hoe = 1'b0;
		repeat (4) @(negedge ref_clk);
	endtask
endmodule

// file: dsp_host_byte_port_bench.sv
`timescale 1ns/1ps
module dsp_host_byte_port_bench
	import dhbp_pkg::*;
;
	logic         ref_clk, rst_n, hoe, doe, re, we, cl, ct, iv;
	dhbp_ctl_type ctl;
	logic [7:0]   hd, dout, q;
	wire  [7:0]   bus;
	logic [15:0]  cod, inb, w, m_out, m_in;
	logic         m_full, m_val;
	int           mismatches, samples_checked;
	integer       seed;
	// undriven lines read as pull-up, never as stale data
	assign bus = doe ? dout : (hoe ? hd : 8'hFF);
	always #20 ref_clk = ~ref_clk;
	dhbp_host_model i_dhbp_host_model (.bus(bus), .ref_clk(ref_clk), .ctl(ctl), .hd(hd),
		.hoe(hoe));
	dhbp_host_port i_dhbp_host_port (.ref_clk(ref_clk), .rst_n(rst_n), .ctl_pin(ctl),
		.port_data_lines_in(bus), .port_data_lines_out(dout), .port_data_lines_oe(doe),
		.read_enable_indication_r(re), .write_enable_indication_r(we),
		.core_outbound_data(cod), .core_outbound_load(cl), .core_inbound_take(ct),
		.host_inbound_data_r(inb), .inbound_valid_r(iv));
	function automatic logic [15:0] st();
		return {14'h0000, m_val, m_full};
	endfunction
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rd(input logic rs, input logic bs, input logic [15:0] e);
		i_dhbp_host_model.access(rs, bs, 1'b0, 8'h00, q);
		chk("read byte", {8'h00, bs ? e[15:8] : e[7:0]}, {8'h00, q});
		chk("bus enable", 16'h0000, {15'h0000, doe});
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (1000) @(posedge ref_clk);
		mismatches++;
		print_verdict();
	end
	initial begin
		seed = 27057;
		{ref_clk, rst_n, cl, ct, cod, m_full, m_val} = '0;
		repeat (4) @(negedge ref_clk);
		rst_n = 1'b1;
		chk("write enable", 16'h0001, {15'h0000, we});
		cod = 16'($random(seed));
		cl = 1'b1;
		m_out = cod;
		m_full = 1'b1;
		@(negedge ref_clk);
		cl = 1'b0;
		@(negedge ref_clk);
		chk("read enable", 16'h0001, {15'h0000, re});
		rd(1'b1, 1'b0, st());
		rd(1'b0, 1'b0, m_out);
		rd(1'b0, 1'b1, m_out);
		m_full = 1'b0;
		chk("read enable", 16'h0000, {15'h0000, re});
		rd(1'b1, 1'b0, st());
		$display("outbound test done");
		w = 16'($random(seed));
		i_dhbp_host_model.access(1'b0, 1'b0, 1'b1, w[7:0], q);
		i_dhbp_host_model.access(1'b0, 1'b1, 1'b1, w[15:8], q);
		i_dhbp_host_model.access(1'b1, 1'b0, 1'b1, 8'hFF, q);
		m_in = w;
		m_val = 1'b1;
		chk("inbound", m_in, inb);
		chk("write enable", 16'h0000, {15'h0000, we});
		rd(1'b1, 1'b0, st());
		rd(1'b1, 1'b1, st());
		ct = 1'b1;
		@(negedge ref_clk);
		ct = 1'b0;
		m_val = 1'b0;
		chk("inbound valid", 16'h0000, {15'h0000, iv});
		@(negedge ref_clk);
		chk("write enable", 16'h0001, {15'h0000, we});
		$display("inbound test done");
		// mid-run reset with a word pending must drop every flag
		cod = 16'($random(seed));
		cl = 1'b1;
		@(negedge ref_clk);
		cl = 1'b0;
		@(negedge ref_clk);
		chk("read enable", 16'h0001, {15'h0000, re});
		rst_n = 1'b0;
		m_full = 1'b0;
		m_in = 16'h0000;
		@(negedge ref_clk);
		chk("read enable", 16'h0000, {15'h0000, re});
		chk("write enable", 16'h0001, {15'h0000, we});
		chk("inbound", m_in, inb);
		chk("inbound valid", 16'h0000, {15'h0000, iv});
		chk("bus enable", 16'h0000, {15'h0000, doe});
		rst_n = 1'b1;
		rd(1'b1, 1'b0, st());
		$display("reset test done");
		print_verdict();
	end
endmodule
